// *** core/cul_latch_flags.sv ***
// Purpose: sticky undervoltage flags for cells 1..17, two status registers
// Assumes: detection pulses and register strobes come from logic on clk
// Notes:   a write of all zeros to either register clears every flag whose cell has no event in that same cycle
//
// Overview of operation
// - Cells 1-16 flags, cell n at bit n-1
// - Detection sets flag; flag holds until cleared
// - All flags read zero after reset
// - Zero write to either register clears flags
// - Cell 17 flag at companion bit zero
`timescale 1ns/1ps
`default_nettype none

module cul_latch_flags
(
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic [cul_pkg::CUL_CELLS-1:0]  cellUndervoltEvt,
   input  wire logic                           regWrEn,
   input  wire logic                           regRdEn,
   input  wire logic [cul_pkg::CUL_ADDR_W-1:0] regAddr,
   input  wire logic [cul_pkg::CUL_DATA_W-1:0] regWrData,
   output logic      [cul_pkg::CUL_DATA_W-1:0] regRdData,
   output logic                                regRdValid,
   output logic      [cul_pkg::CUL_CELLS-1:0]  undervoltFlags,
   output logic                                anyUndervolt
);
   import cul_pkg::*;

   cul_state_t state_r;
   cul_state_t state_nxt;

   logic clearHit;
   logic hitLow;
   logic hitHigh;

   function automatic logic addrIs(input logic [CUL_ADDR_W-1:0] a,
                                   input logic [CUL_ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   function automatic logic [CUL_DATA_W-1:0] highWord(input cul_state_t s);
      logic [CUL_DATA_W-1:0] w;
      // bits 15:6 are not stored; they always read zero
      w = '0;
      w[CUL_HIGH_FLAG_POS] = s.flagHigh;
      w[CUL_HIGH_RSVD_MSB:CUL_HIGH_RSVD_LSB] = s.rsvdHigh;
      return w;
   endfunction

   assign hitLow   = addrIs(regAddr, CUL_OFS_LOW);
   assign hitHigh  = addrIs(regAddr, CUL_OFS_HIGH);
   // only the exact all-zero value acknowledges; other writes keep flags
   assign clearHit = regWrEn && (hitLow || hitHigh)
                     && (regWrData == CUL_CLEAR_VALUE);

   always_comb begin
      state_nxt = state_r;
      state_nxt.rdValid = 1'b0;
      if (clearHit) begin
         state_nxt.flagsLow = CUL_RST_LOW[CUL_LOW_CELLS-1:0];
         state_nxt.flagHigh = 1'b0;
      end
      // reserved bits just store what software writes
      if (regWrEn && hitHigh) begin
         state_nxt.rsvdHigh =
            regWrData[CUL_HIGH_RSVD_MSB:CUL_HIGH_RSVD_LSB];
      end
      // set after clear so an event in the clearing cycle survives
      for (int i = 0; i < CUL_LOW_CELLS; i++) begin
         if (cellUndervoltEvt[i]) begin
            state_nxt.flagsLow[i] = 1'b1;
         end
      end
      if (cellUndervoltEvt[CUL_CELLS-1]) begin
         state_nxt.flagHigh = 1'b1;
      end
      if (regRdEn) begin
         state_nxt.rdValid = 1'b1;
         if (hitLow) begin
            state_nxt.rdData = state_r.flagsLow;
         end else if (hitHigh) begin
            state_nxt.rdData = highWord(state_r);
         end else begin
            state_nxt.rdData = CUL_RD_UNMAPPED;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r.flagsLow <= CUL_RST_LOW[CUL_LOW_CELLS-1:0];
         state_r.flagHigh <= CUL_RST_HIGH[CUL_HIGH_FLAG_POS];
         state_r.rsvdHigh <= CUL_RST_HIGH[CUL_HIGH_RSVD_MSB:CUL_HIGH_RSVD_LSB];
         state_r.rdData   <= CUL_RD_UNMAPPED;
         state_r.rdValid  <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign regRdData      = state_r.rdData;
   assign regRdValid     = state_r.rdValid;
   assign undervoltFlags = {state_r.flagHigh, state_r.flagsLow};
   assign anyUndervolt   = |undervoltFlags;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_reset_flags_zero: assert property (
      $past(rst) |-> (undervoltFlags == '0))
      else $error("flags not zero after reset release");

   a_low_read_map: assert property (
      (regRdEn && hitLow) |=> (regRdValid
         && regRdData == $past(undervoltFlags[CUL_LOW_CELLS-1:0])))
      else $error("low register read does not show cell flags");

   a_high_read_map: assert property (
      (regRdEn && hitHigh) |=> (regRdValid
         && regRdData[0] == $past(undervoltFlags[CUL_CELLS-1])
         && regRdData[15:6] == '0))
      else $error("high register read wrong");

   a_event_sets_flag: assert property (
      cellUndervoltEvt[0] |=> undervoltFlags[0] [*1])
      else $error("cell 1 event did not set flag");

   a_flag_holds: assert property (
      (undervoltFlags[15] && !clearHit) |=> undervoltFlags[15])
      else $error("cell 16 flag dropped without a clear");

   a_no_spurious_set: assert property (
      (!undervoltFlags[7] && !cellUndervoltEvt[7]) |=> !undervoltFlags[7])
      else $error("cell 8 flag rose without an event");

   a_zero_write_clears: assert property (
      (clearHit && cellUndervoltEvt == '0) |=> (undervoltFlags == '0))
      else $error("zero write did not clear flags");

   a_event_beats_clear: assert property (
      (clearHit && cellUndervoltEvt[CUL_CELLS-1])
         |=> undervoltFlags[CUL_CELLS-1]
             ##1 (undervoltFlags[CUL_CELLS-1] || $past(clearHit)))
      else $error("event lost during clearing write");

   a_high_flag_sticky: assert property (
      cellUndervoltEvt[CUL_CELLS-1] ##1 (!clearHit) [*2]
         |=> undervoltFlags[CUL_CELLS-1])
      else $error("cell 17 flag not sticky");

   // port-level view of an acknowledging write, kept apart from clearHit
   // so the checks below do not lean on the decode they guard
   logic zeroWrSeen;
   assign zeroWrSeen = regWrEn
                       && (regAddr == CUL_OFS_LOW || regAddr == CUL_OFS_HIGH)
                       && (regWrData == CUL_CLEAR_VALUE);

   a_sticky_or_event: assert property (
      !zeroWrSeen |=> (undervoltFlags
         == ($past(undervoltFlags) | $past(cellUndervoltEvt))))
      else $error("flags changed other than by a detection event");

   a_clear_keeps_events: assert property (
      zeroWrSeen |=> (undervoltFlags == $past(cellUndervoltEvt)))
      else $error("clearing write left the wrong flags");

   a_read_valid_pulse: assert property (
      regRdEn |=> regRdValid)
      else $error("read strobe not answered in the next cycle");

   a_valid_needs_read: assert property (
      !regRdEn |=> !regRdValid)
      else $error("read valid without a read strobe");

   a_rd_data_holds: assert property (
      !regRdEn |=> $stable(regRdData))
      else $error("read data moved without a read");

   // unmapped indices still answer, so a host poll never stalls
   a_unmapped_read_zero: assert property (
      (regRdEn && regAddr != CUL_OFS_LOW && regAddr != CUL_OFS_HIGH)
         |=> (regRdData == CUL_RD_UNMAPPED))
      else $error("read of an unmapped index returned data");

   a_rsvd_readback: assert property (
      (regWrEn && regAddr == CUL_OFS_HIGH)
         ##1 (regRdEn && regAddr == CUL_OFS_HIGH)
         |=> (regRdData[CUL_HIGH_RSVD_MSB:CUL_HIGH_RSVD_LSB]
              == $past(regWrData[CUL_HIGH_RSVD_MSB:CUL_HIGH_RSVD_LSB], 2)))
      else $error("reserved bits do not read back as written");

   a_reset_read_idle: assert property (
      $past(rst) |-> (!regRdValid
         && regRdData == CUL_RD_UNMAPPED))
      else $error("read port not idle after reset release");

   // one set and one hold check per cell, so a crossed bit shows up
   for (genvar c = 0; c < CUL_CELLS; c++) begin : g_cellChk
      a_cell_evt_sets: assert property (
         @(posedge clk) disable iff (rst)
         cellUndervoltEvt[c] |=> undervoltFlags[c])
         else $error("detection event did not set its own flag");

      a_cell_holds: assert property (
         @(posedge clk) disable iff (rst)
         (undervoltFlags[c] && !zeroWrSeen) |=> undervoltFlags[c])
         else $error("flag dropped without a clearing write");
   end

   c_clear_via_high: cover property (
      undervoltFlags[3] ##1 (clearHit && hitHigh) ##1 !undervoltFlags[3]);
   c_event_and_clear: cover property (clearHit && cellUndervoltEvt != '0);
   c_read_set_flag: cover property (
      regRdEn && hitLow && undervoltFlags[0]);
   c_all_cells_set: cover property (&undervoltFlags);
   c_unmapped_read: cover property (regRdEn && !hitLow && !hitHigh);
endmodule

`default_nettype wire

// *** pkg/cul_pkg.sv ***
// Purpose: constants for the cell undervoltage latch flag registers
// Assumes: 8-bit register index, 16-bit register data
// Notes:   offsets are register indices as seen by the serial decoder
package cul_pkg;
   localparam int          CUL_ADDR_W      = 8;
   localparam int          CUL_DATA_W      = 16;
   localparam int          CUL_LOW_CELLS   = 16;
   localparam int          CUL_CELLS       = 17;
   localparam logic [7:0]  CUL_OFS_LOW     = 8'h4F;
   localparam logic [7:0]  CUL_OFS_HIGH    = 8'h50;
   localparam logic [15:0] CUL_RST_LOW     = 16'h0000;
   localparam logic [15:0] CUL_RST_HIGH    = 16'h0000;
   localparam logic [15:0] CUL_CLEAR_VALUE = 16'h0000;
   localparam int          CUL_HIGH_FLAG_POS = 0;
   localparam int          CUL_HIGH_RSVD_LSB = 1;
   localparam int          CUL_HIGH_RSVD_MSB = 5;
   localparam logic [15:0] CUL_RD_UNMAPPED = 16'h0000;

   typedef struct packed {
      logic [CUL_LOW_CELLS-1:0] flagsLow;
      logic                     flagHigh;
      logic [4:0]               rsvdHigh;
      logic [CUL_DATA_W-1:0]    rdData;
      logic                     rdValid;
   } cul_state_t;
endpackage

// *** verification/cul_host_model.sv ***
// Purpose: host side of the flag register port
// Assumes: requests launched at the falling edge
// Notes:   one request per call, held over one rising edge
`timescale 1ns/1ps
`default_nettype none
module cul_host_model (
   input  wire logic        clk,
   output logic             regWrEn,
   output logic             regRdEn,
   output logic [7:0]       regAddr,
   output logic [15:0]      regWrData
);
   initial begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 8'h00;
      regWrData = 16'h0000;
   end
   // strobes only change here, so no double drive in one step
   task automatic op(input logic w, r, input logic [7:0] a,
                     input logic [15:0] d);
      regWrEn = w;
      regRdEn = r;
      regAddr = a;
      regWrData = d;
      @(negedge clk);
   endtask
endmodule
`default_nettype wire

// *** verification/cul_latch_flags_tb.sv ***
// Purpose: random self-checking bench for the undervoltage flags
// Assumes: one-cycle read latency, set beats clear
// Notes:   unmapped index 0x33 must neither clear nor answer data
`timescale 1ns/1ps
`default_nettype none
module cul_latch_flags_tb;
   import cul_pkg::*;
   logic        clk, rst, wr, rd, rv, any, rvExp, w, q;
   logic [16:0] evt, flags, mdl;
   logic [7:0]  adr, a;
   logic [15:0] wd, rdat, rdExp, d;
   logic [31:0] seed;
   logic [4:0]  rsv;
   int          error_cnt, checked;
   cul_host_model HOST (.clk(clk), .regWrEn(wr), .regRdEn(rd),
      .regAddr(adr), .regWrData(wd));
   cul_latch_flags DUT (.clk(clk), .rst(rst), .cellUndervoltEvt(evt),
      .regWrEn(wr), .regRdEn(rd), .regAddr(adr), .regWrData(wd),
      .regRdData(rdat), .regRdValid(rv), .undervoltFlags(flags),
      .anyUndervolt(any));
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic [16:0] nxt(logic [16:0] f, e, logic [7:0] a,
                                       logic [15:0] d, logic w);
      if (w && d == 16'h0000 && (a == 8'h4F || a == 8'h50)) return e;
      return f | e;
   endfunction
   task automatic chk(input logic [16:0] s, e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("FAIL %0t value differs from model", $time);
      end
   endtask
   task automatic tally_and_finish;
      if (error_cnt == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mdl <= 17'h00000;
         rvExp <= 1'b0;
         rsv <= 5'h00;
      end else begin
         mdl <= nxt(mdl, evt, adr, wd, wr);
         rvExp <= rd;
         // reserved bits of the companion register are plain storage
         if (wr && adr == 8'h50) rsv <= wd[5:1];
         if (rd) rdExp <= adr == 8'h4F ? mdl[15:0] :
            adr == 8'h50 ? {10'h000, rsv, mdl[16]} : 16'h0000;
      end
   end
   // settle past any reset edge launched at the same falling edge
   always @(negedge clk) begin
      #2;
      if (!rst) begin
         chk(flags, mdl);
         chk(17'(any), 17'(|mdl));
         chk(17'(rv), 17'(rvExp));
         if (rv) chk(17'(rdat), 17'(rdExp));
      end
   end
   initial begin
      {rst, evt, seed, error_cnt, checked} = {1'b1, 17'h0, 32'h31, 64'h0};
      repeat (12) @(negedge clk);
      chk(flags, 17'h00000);
      rst = 1'b0;
      for (int i = 0; i < 4000; i++) begin
         seed = xs(seed);
         evt = seed[2:0] == 3'h0 ? 17'(32'h1 << seed[8:4]) : 17'h00000;
         a = seed[10:9] == 2'h1 ? 8'h50 : seed[10:9] == 2'h2 ? 8'h33 : 8'h4F;
         w = seed[13:11] == 3'h0;
         q = seed[15:14] != 2'h0;
         d = seed[17:16] == 2'h0 ? 16'h0000 : seed[31:16];
         rst = i == 2000;
         HOST.op(w, q, a, d);
         if (rst) chk(flags, 17'h00000);
      end
      // corners: all cells in a clearing cycle, software cannot set flags
      evt = 17'h1FFFF;
      HOST.op(1'b1, 1'b1, 8'h50, 16'h0000);
      evt = 17'h00000;
      HOST.op(1'b0, 1'b1, 8'h4F, 16'h0000);
      HOST.op(1'b1, 1'b0, 8'h4F, 16'h0000);
      HOST.op(1'b1, 1'b0, 8'h50, 16'hFFFF);
      HOST.op(1'b0, 1'b1, 8'h50, 16'h0000);
      HOST.op(1'b0, 1'b1, 8'h33, 16'h0000);
      HOST.op(1'b0, 1'b0, 8'h00, 16'h0000);
      chk(flags, 17'h00000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
